/* File: rtl/eeg_pkg.sv */
// Shared constants and state encoding for the group error-correction block.
package eeg_pkg;

  // --------------------------------------------------------------------------
  // Address and group geometry
  // --------------------------------------------------------------------------
  localparam int ADDR_W       = 16;  // Byte address width of the array.
  localparam int GRP_LSB      = 2;   // Byte-in-group bits; a group is 4 bytes.
  localparam int GRP_BYTES    = 4;   // Bytes protected together.
  localparam int ARR_AW       = 14;  // Group index width into the array.
  localparam int PAGE_BYTES   = 128; // Bytes held by one page transfer.
  localparam int PAGE_LSB     = 7;   // Low address bits that wrap in a page.
  localparam int PAGE_W       = 9;   // Page number width.
  localparam int PAGE_GRPS    = 32;  // Groups inside one page.
  localparam int PGRP_W       = 5;   // Width of the in-page group index.

  // --------------------------------------------------------------------------
  // Code word layout
  // --------------------------------------------------------------------------
  localparam int DATA_W       = 32;  // Data bits per group.
  localparam int HAM_W        = 6;   // Hamming check bits.
  localparam int CHK_W        = 7;   // Hamming bits plus overall parity.
  localparam int WORD_W       = 39;  // Stored word: check bits above data.
  localparam int CODE_POS_MAX = 38;  // Highest Hamming position in use.

  // --------------------------------------------------------------------------
  // Timing counts in core clock cycles
  // --------------------------------------------------------------------------
  localparam int RD_LATENCY   = 3;   // Request to returned byte, fixed.
  localparam int PROG_MAX     = 130; // Bound on cycles from start to done; worst is 128.

  // --------------------------------------------------------------------------
  // Sequencer states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_RD_ISSUE = 8'h02,
    ST_RD_CAPT  = 8'h04,
    ST_PG_SCAN  = 8'h08,
    ST_PG_READ  = 8'h10,
    ST_PG_MERGE = 8'h20,
    ST_PG_WRITE = 8'h40,
    ST_PG_DONE  = 8'h80
  } eeg_state_t;

endpackage : eeg_pkg

/* File: rtl/eeg_codec.sv */
// Extended Hamming encoder and single-error corrector for one 4-byte group.
`timescale 1ns/1ps
`default_nettype none

module eeg_codec (
  input  wire logic [31:0] data,        // Data bits as stored or to be stored.
  input  wire logic [6:0]  chk,         // Stored check bits; zero when encoding.
  output logic      [31:0] fixed,       // Data with a lone data-bit error undone.
  output logic      [6:0]  gen,         // Check bits generated from data.
  output logic             single_err,  // One bit of the word was flipped.
  output logic             multi_err    // Two bits flipped; left alone.
);

  // --------------------------------------------------------------------------
  // Check generation and correction
  // --------------------------------------------------------------------------
  // Data bits sit at every non power-of-two position from 3 upward; the
  // syndrome then names the flipped position directly. The overall parity
  // separates one flip from two, which is why a double error is never touched.
  always_comb begin
    int         p;
    int         n;
    int         k;
    logic [5:0] syn;
    logic       perr;
    // Loop indices and intermediates start from known values on every pass.
    p     = 0;
    k     = 0;
    syn   = '0;
    perr  = 1'b0;
    gen   = '0;
    fixed = data;
    n     = 0;
    for (p = 1; p <= eeg_pkg::CODE_POS_MAX; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (k = 0; k < eeg_pkg::HAM_W; k++) begin
          if (p[k]) begin
            gen[k] = gen[k] ^ data[n];
          end
        end
        n = n + 1;
      end
    end
    gen[6]     = ^{data, gen[5:0]};
    syn        = chk[5:0] ^ gen[5:0];
    perr       = ^{data, chk};
    single_err = perr;
    multi_err  = (syn != 6'h0) && !perr;
    n          = 0;
    for (p = 1; p <= eeg_pkg::CODE_POS_MAX; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (perr && (syn == p[5:0])) begin
          fixed[n] = ~data[n];
        end
        n = n + 1;
      end
    end
  end

endmodule : eeg_codec
`default_nettype wire

/* File: rtl/eeg_core.sv */
// Group error-correction engine between the access sequencer and the array.
//
// Overview of operation
// - Correction is invisible; fixed timing, no extra traffic.
// - Groups are four aligned consecutive byte addresses.
// - Single wrong bit in group is corrected.
// - Single byte write rewrites whole group, new check.
// - Byte or page write starts one programming cycle.
// - Page write advances only the seven low bits.
// - Group programming begins only at stop condition.
`timescale 1ns/1ps
`default_nettype none

module eeg_core (
  input  wire logic        core_clk,    // Core clock, 40 MHz.
  input  wire logic        reset_n,     // Asynchronous reset, active low.
  input  wire logic        wr_begin,    // Pulse: write transfer addressed.
  input  wire logic [15:0] wr_addr,     // Start byte address of the write.
  input  wire logic        wr_byte,     // Pulse: one data byte received.
  input  wire logic [7:0]  wr_data,     // Received data byte.
  input  wire logic        wr_stop,     // Pulse: stop ended the write transfer.
  input  wire logic        rd_req,      // Pulse: byte wanted for the bus.
  input  wire logic [15:0] rd_addr,     // Byte address to read.
  output logic      [7:0]  rd_data,     // Corrected byte.
  output logic             rd_valid,    // Pulse: rd_data is valid.
  output logic             busy,        // Engine is not idle.
  output logic             prog_start,  // Pulse: programming cycle started.
  output logic             prog_done,   // Pulse: programming cycle finished.
  output logic      [13:0] arr_addr,    // Group index into the array.
  output logic             arr_rd_en,   // Array read; data one cycle later.
  input  wire logic [38:0] arr_rdata,   // Stored word, check bits on top.
  output logic             arr_wr_en,   // Array word program strobe.
  output logic      [38:0] arr_wdata    // Word to program.
);

  // --------------------------------------------------------------------------
  // State record
  // --------------------------------------------------------------------------
  typedef struct packed {
    eeg_pkg::eeg_state_t st;          // Sequencer state.
    logic [8:0]          pbase;       // Page number of the write transfer.
    logic [6:0]          ptr;         // Byte pointer inside the page.
    logic [1023:0]       pbuf;        // Received page bytes.
    logic [127:0]        mask;        // Which page bytes were received.
    logic [4:0]          grp;         // Group being programmed.
    logic [13:0]         rd_grp;      // Group being read.
    logic [1:0]          rd_sel;      // Byte lane being read.
    logic [7:0]          rd_data;     // Returned byte.
    logic                rd_valid;    // Returned byte strobe.
    logic [38:0]         wdata;       // Word held for programming.
    logic                prog_start;  // Programming start strobe.
  } eeg_regs_t;

  eeg_regs_t   r;       // Registered state.
  eeg_regs_t   next_r;  // Next state.

  logic [31:0] dec_fixed;   // Stored data after correction.
  logic        dec_single;  // Stored word held one flipped bit.
  logic        dec_multi;   // Stored word held several flipped bits.
  logic [31:0] merged;      // Fresh bytes laid over corrected old bytes.
  logic [6:0]  enc_gen;     // Check bits for the merged group.
  logic [3:0]  grp_mask;    // Received-byte mask of the current group.

  // --------------------------------------------------------------------------
  // Codecs
  // --------------------------------------------------------------------------
  // The decoder serves both bus reads and the read half of a group rewrite.
  eeg_codec u_dec (
    .data       (arr_rdata[31:0]),
    .chk        (arr_rdata[38:32]),
    .fixed      (dec_fixed),
    .gen        (),
    .single_err (dec_single),
    .multi_err  (dec_multi)
  );

  // The encoder only generates; its check input is tied to zero.
  eeg_codec u_enc (
    .data       (merged),
    .chk        (7'h00),
    .fixed      (),
    .gen        (enc_gen),
    .single_err (),
    .multi_err  ()
  );

  // --------------------------------------------------------------------------
  // Group merge
  // --------------------------------------------------------------------------
  // Unwritten lanes keep the corrected old byte, so a latent single error in
  // a neighbour is scrubbed instead of being sealed under a new check.
  always_comb begin
    int b;
    b        = 0;
    grp_mask = r.mask[r.grp * eeg_pkg::GRP_BYTES +: eeg_pkg::GRP_BYTES];
    merged   = dec_fixed;
    for (b = 0; b < eeg_pkg::GRP_BYTES; b++) begin
      if (grp_mask[b]) begin
        merged[b * 8 +: 8] = r.pbuf[(r.grp * eeg_pkg::GRP_BYTES + b) * 8 +: 8];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    next_r            = r;
    next_r.rd_valid   = 1'b0;
    next_r.prog_start = 1'b0;
    case (r.st)
      eeg_pkg::ST_IDLE: begin
        // Page collection: the page number is frozen, the pointer wraps.
        if (wr_begin) begin
          next_r.pbase = wr_addr[15:eeg_pkg::PAGE_LSB];
          next_r.ptr   = wr_addr[eeg_pkg::PAGE_LSB-1:0];
          next_r.mask  = '0;
        end
        if (wr_byte) begin
          next_r.pbuf[next_r.ptr * 8 +: 8] = wr_data;
          next_r.mask[next_r.ptr]          = 1'b1;
          next_r.ptr                       = next_r.ptr + 7'h01;
        end
        // Nothing touches the array until the stop; a dummy write with no
        // data bytes programs nothing.
        if (wr_stop && (|r.mask)) begin
          next_r.st         = eeg_pkg::ST_PG_SCAN;
          next_r.grp        = 5'h00;
          next_r.prog_start = 1'b1;
        end else if (rd_req) begin
          next_r.rd_grp = rd_addr[15:eeg_pkg::GRP_LSB];
          next_r.rd_sel = rd_addr[eeg_pkg::GRP_LSB-1:0];
          next_r.st     = eeg_pkg::ST_RD_ISSUE;
        end
      end
      eeg_pkg::ST_RD_ISSUE: begin
        // Array read is strobed here; the word arrives next cycle.
        next_r.st = eeg_pkg::ST_RD_CAPT;
      end
      eeg_pkg::ST_RD_CAPT: begin
        // Same latency whatever the decoder found; errors are never reported.
        next_r.rd_data  = dec_fixed[r.rd_sel * 8 +: 8];
        next_r.rd_valid = 1'b1;
        next_r.st       = eeg_pkg::ST_IDLE;
      end
      eeg_pkg::ST_PG_SCAN: begin
        // Skip groups the transfer never touched.
        if (|grp_mask) begin
          next_r.st = eeg_pkg::ST_PG_READ;
        end else if (r.grp == 5'h1f) begin
          next_r.st = eeg_pkg::ST_PG_DONE;
        end else begin
          next_r.grp = r.grp + 5'h01;
        end
      end
      eeg_pkg::ST_PG_READ: begin
        next_r.st = eeg_pkg::ST_PG_MERGE;
      end
      eeg_pkg::ST_PG_MERGE: begin
        next_r.wdata = {enc_gen, merged};
        next_r.st    = eeg_pkg::ST_PG_WRITE;
      end
      eeg_pkg::ST_PG_WRITE: begin
        if (r.grp == 5'h1f) begin
          next_r.st = eeg_pkg::ST_PG_DONE;
        end else begin
          next_r.grp = r.grp + 5'h01;
          next_r.st  = eeg_pkg::ST_PG_SCAN;
        end
      end
      eeg_pkg::ST_PG_DONE: begin
        next_r.mask = '0;
        next_r.st   = eeg_pkg::ST_IDLE;
      end
      default: begin
        next_r.st = eeg_pkg::ST_IDLE;
      end
    endcase
  end

  // State register; every field resets to a constant.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r    <= '0;
      r.st <= eeg_pkg::ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign rd_data    = r.rd_data;
  assign rd_valid   = r.rd_valid;
  assign prog_start = r.prog_start;
  assign prog_done  = (r.st == eeg_pkg::ST_PG_DONE);
  assign busy       = (r.st != eeg_pkg::ST_IDLE);
  assign arr_rd_en  = (r.st == eeg_pkg::ST_RD_ISSUE) || (r.st == eeg_pkg::ST_PG_READ);
  assign arr_wr_en  = (r.st == eeg_pkg::ST_PG_WRITE);
  assign arr_wdata  = r.wdata;
  assign arr_addr   = (r.st == eeg_pkg::ST_RD_ISSUE) ? r.rd_grp : {r.pbase, r.grp};

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  logic idle;  // Engine is free for new work.
  assign idle = (r.st == eeg_pkg::ST_IDLE);

  sequence read_taken_s;
    idle && rd_req && !(wr_stop && (|r.mask));
  endsequence

  sequence prog_kick_s;
    idle && wr_stop && (|r.mask);
  endsequence

  rd_latency_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    read_taken_s |=> !rd_valid [*2] ##1 rd_valid)
    else $error("Read answer not exactly three cycles after request");

  grp_addr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    read_taken_s |=> arr_rd_en && (arr_addr == $past(rd_addr[15:2])))
    else $error("Read did not address the aligned group");

  fix_byte_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (r.st == eeg_pkg::ST_RD_CAPT) && dec_single
    |=> rd_data == $past(dec_fixed[r.rd_sel * 8 +: 8]))
    else $error("Corrected byte not returned");

  no_fix_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    dec_multi |-> (dec_fixed == arr_rdata[31:0]))
    else $error("Multi-bit error was altered");

  rmw_word_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (r.st == eeg_pkg::ST_PG_MERGE)
    |=> arr_wr_en && (arr_wdata == {$past(enc_gen), $past(merged)}))
    else $error("Group rewrite word wrong");

  prog_kick_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    prog_kick_s |=> prog_start ##1 !prog_start)
    else $error("Programming start not a single pulse");

  stop_only_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (arr_wr_en || prog_start) |-> !$past(idle) || $past(wr_stop))
    else $error("Programming began without a stop");

  prog_bound_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    prog_start |-> ##[1:130] prog_done)
    else $error("Programming did not finish in time");

  ptr_wrap_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    idle && wr_byte && !wr_begin
    |=> (r.ptr == $past(r.ptr) + 7'h01) && (r.pbase == $past(r.pbase)))
    else $error("Page pointer advanced wrongly");

endmodule : eeg_core
`default_nettype wire

/* File: verification/eeg_array_model.sv */
// Behavioural model of the nonvolatile array behind the correction engine.
`timescale 1ns/1ps
`default_nettype none

module eeg_array_model (
  input  wire logic        core_clk,   // Core clock.
  input  wire logic        reset_n,    // Asynchronous reset, active low.
  input  wire logic [13:0] arr_addr,   // Group index.
  input  wire logic        arr_rd_en,  // Read strobe.
  output logic      [38:0] arr_rdata,  // Word, valid the cycle after the strobe.
  input  wire logic        arr_wr_en,  // Program strobe.
  input  wire logic [38:0] arr_wdata   // Word to program.
);
  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [38:0] mem [0:16383];  // All zero is a legal code word.
  int          cyc [0:16383];  // Programming cycles seen by each group.

  initial begin
    foreach (mem[i]) begin
      mem[i] = '0;
      cyc[i] = 0;
    end
  end

  // --------------------------------------------------------------------------
  // Access
  // --------------------------------------------------------------------------
  // Read data stands for one cycle only; afterwards the bus inverts every cycle,
  // so an engine that samples one cycle late sees garbage instead of a lucky match.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      arr_rdata <= '0;
    end else if (arr_rd_en) begin
      arr_rdata <= mem[arr_addr];
    end else begin
      arr_rdata <= ~arr_rdata;
    end
  end

  // Each program strobe is one endurance cycle charged to the whole group.
  always @(posedge core_clk) begin
    if (reset_n && arr_wr_en) begin
      mem[arr_addr] <= arr_wdata;
      cyc[arr_addr] <= cyc[arr_addr] + 1;
    end
  end
endmodule : eeg_array_model
`default_nettype wire

/* File: verification/tb_eeprom_group_ecc.sv */
// Self-checking testbench for the group error-correction engine.
`timescale 1ns/1ps
`default_nettype none

module tb_eeprom_group_ecc;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic        core_clk, reset_n, wr_begin, wr_byte, wr_stop, rd_req;
  logic [15:0] wr_addr, rd_addr;
  logic [7:0]  wr_data, rd_data;
  logic        rd_valid, busy, prog_start, prog_done, arr_rd_en, arr_wr_en;
  logic [13:0] arr_addr;
  logic [38:0] arr_rdata, arr_wdata;
  int          errors = 0;
  int          num_checks = 0;
  int          n_prog = 0;  // Programming starts seen so far.

  eeg_core u_dut (.core_clk(core_clk), .reset_n(reset_n), .wr_begin(wr_begin),
    .wr_addr(wr_addr), .wr_byte(wr_byte), .wr_data(wr_data), .wr_stop(wr_stop),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .busy(busy), .prog_start(prog_start), .prog_done(prog_done), .arr_addr(arr_addr),
    .arr_rd_en(arr_rd_en), .arr_rdata(arr_rdata), .arr_wr_en(arr_wr_en),
    .arr_wdata(arr_wdata));

  eeg_array_model u_mem (.core_clk(core_clk), .reset_n(reset_n), .arr_addr(arr_addr),
    .arr_rd_en(arr_rd_en), .arr_rdata(arr_rdata), .arr_wr_en(arr_wr_en),
    .arr_wdata(arr_wdata));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (prog_start === 1'b1) begin
      n_prog <= n_prog + 1;
    end
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Independent extended Hamming encoder; data at non-power-of-two positions.
  function automatic logic [38:0] enc(input logic [31:0] d);
    logic [38:1] cw;
    logic [6:0]  c;
    int          j;
    cw = '0;
    c  = '0;
    j  = 0;
    for (int p = 3; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p] = d[j];
        j++;
      end
    end
    for (int k = 0; k < 6; k++) begin
      for (int p = 1; p <= 38; p++) begin
        if (p[k]) c[k] ^= cw[p];
      end
    end
    c[6] = (^d) ^ (^c[5:0]);
    return {c, d};
  endfunction : enc

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [38:0] got, input logic [38:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask : chk

  // One read; the answer must come exactly three cycles after it is taken.
  task automatic rd_check(input logic [15:0] a, input logic [7:0] exp);
    int n;
    @(posedge core_clk);
    rd_req  <= 1'b1;
    rd_addr <= a;
    @(posedge core_clk);
    rd_req <= 1'b0;
    #1;
    // The cycle after the request is the first one counted.
    n = 1;
    while (rd_valid !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 8) begin
      errors++;
      end_sim();
    end else begin
      chk(39'(n), 39'd3);
      chk(39'(rd_data), 39'(exp));
    end
  endtask : rd_check

  // Write n bytes of d from address a, then stop and wait for programming.
  task automatic wr_xfer(input logic [15:0] a, input logic [31:0] d, input int n);
    int n0;
    int w;
    n0 = n_prog;
    @(posedge core_clk);
    wr_begin <= 1'b1;
    wr_addr  <= a;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      wr_begin <= 1'b0;
      wr_byte  <= 1'b1;
      wr_data  <= d[8*i+:8];
    end
    @(posedge core_clk);
    wr_byte <= 1'b0;
    wr_stop <= 1'b1;
    @(posedge core_clk);
    wr_stop <= 1'b0;
    #1;
    // The start pulse stands only in the cycle right after the stop.
    chk(39'(n_prog), 39'(n0));
    chk(39'(prog_start), 39'd1);
    chk(39'(busy), 39'd1);
    w = 0;
    while (prog_done !== 1'b1 && w < 140) begin
      @(posedge core_clk);
      #1;
      w++;
    end
    if (w >= 140) begin
      errors++;
      end_sim();
    end else begin
      @(posedge core_clk);
      #1;
      chk(39'(n_prog), 39'(n0 + 1));
      chk(39'(busy), 39'd0);
    end
  endtask : wr_xfer

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_clean();
    u_mem.mem[16] = enc(32'hDDCC_BBAA);
    for (int i = 0; i < 4; i++) rd_check(16'(16'h0040 + i), 8'(32'hDDCC_BBAA >> (8 * i)));
    $display("test clean read done");
  endtask : t_clean

  task automatic t_single();
    int pos [5] = '{0, 13, 31, 34, 38};
    foreach (pos[k]) begin
      u_mem.mem[17] = enc(32'h8765_4321) ^ (39'd1 << pos[k]);
      for (int i = 0; i < 4; i++) rd_check(16'(16'h0044 + i), 8'(32'h8765_4321 >> (8 * i)));
    end
    $display("test single error done");
  endtask : t_single

  task automatic t_double();
    u_mem.mem[19] = enc(32'h1122_3344) ^ 39'h000_0000_0201;
    rd_check(16'h004C, 8'h45);
    rd_check(16'h004D, 8'h31);
    $display("test double error done");
  endtask : t_double

  // Address-only write, as a random read sets up; nothing may be programmed.
  task automatic t_dummy();
    int n0;
    n0 = n_prog;
    @(posedge core_clk);
    wr_begin <= 1'b1;
    wr_addr  <= 16'h0040;
    @(posedge core_clk);
    wr_begin <= 1'b0;
    wr_stop  <= 1'b1;
    @(posedge core_clk);
    wr_stop <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(39'(n_prog), 39'(n0));
    chk(39'(busy), 39'd0);
    rd_check(16'h0043, 8'hDD);
    $display("test dummy write done");
  endtask : t_dummy

  // Byte write into a group whose top byte is stored with one flipped bit.
  task automatic t_byte_write();
    u_mem.mem[64] = enc(32'h4433_2211) ^ (39'd1 << 27);
    wr_xfer(16'h0101, 32'h0000_00AB, 1);
    chk(u_mem.mem[64], enc(32'h4433_AB11));
    chk(39'(u_mem.cyc[64]), 39'd1);
    chk(39'(u_mem.cyc[65]), 39'd0);
    $display("test byte write done");
  endtask : t_byte_write

  // Page write that wraps from the last group of a page to its first.
  task automatic t_page_wrap();
    u_mem.mem[191] = enc(32'h7654_3210);
    u_mem.mem[160] = enc(32'hFEDC_BA98);
    wr_xfer(16'h02FE, 32'h4433_2211, 4);
    chk(u_mem.mem[191], enc(32'h2211_3210));
    chk(u_mem.mem[160], enc(32'hFEDC_4433));
    chk(39'(u_mem.cyc[192]), 39'd0);
    chk(39'(u_mem.cyc[161]), 39'd0);
    rd_check(16'h0281, 8'h44);
    $display("test page wrap done");
  endtask : t_page_wrap

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    reset_n  = 1'b0;
    wr_begin = 1'b0;
    wr_byte  = 1'b0;
    wr_stop  = 1'b0;
    rd_req   = 1'b0;
    wr_addr  = '0;
    rd_addr  = '0;
    wr_data  = '0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    chk({busy, rd_valid, prog_start, prog_done, arr_rd_en, arr_wr_en}, 39'd0);
    t_clean();
    t_single();
    t_double();
    t_dummy();
    t_byte_write();
    t_page_wrap();
    end_sim();
  end
endmodule : tb_eeprom_group_ecc
`default_nettype wire
